// [src/dpc_pkg.sv]
// package: register map, field layout and carrier types of the dac path block
package dpc_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_HP_EN = 8'h0E;
  localparam logic [7:0] IDX_LINE_EN = 8'h0F;
  localparam logic [7:0] IDX_CONV_EN = 8'h12;
  localparam logic [7:0] IDX_DAC_CTL = 8'h21;
  localparam logic [7:0] IDX_HP_STAGE = 8'h5A;
  localparam logic [7:0] IDX_LINE_STAGE = 8'h5E;
  localparam logic [7:0] IDX_STATUS = 8'h60;

  // reset values
  localparam logic [15:0] RST_HP_EN = 16'h0000;
  localparam logic [15:0] RST_LINE_EN = 16'h0000;
  localparam logic [15:0] RST_CONV_EN = 16'h0000;
  localparam logic [15:0] RST_DAC_CTL = 16'h0000;
  localparam logic [15:0] RST_STAGE = 16'h0000;

  // left/right bit pair used by the amp and converter enable registers
  localparam int BIT_LEFT = 1;
  localparam int BIT_RIGHT = 0;

  // dac digital control fields
  localparam int BIT_MONO = 12;
  localparam int BIT_SLOPE = 11;
  localparam int BIT_OSR = 6;
  localparam int BIT_EMPHASIS_UNDO_SELECT_HI = 2;
  localparam int BIT_EMPHASIS_UNDO_SELECT_LO = 1;

  // stage register fields, left half then right half
  localparam int BIT_L_SHORT_REL = 7;
  localparam int BIT_L_OUT_STAGE = 6;
  localparam int BIT_L_MID_STAGE = 5;
  localparam int BIT_L_IN_STAGE = 4;
  localparam int BIT_R_SHORT_REL = 3;
  localparam int BIT_R_OUT_STAGE = 2;
  localparam int BIT_R_MID_STAGE = 1;
  localparam int BIT_R_IN_STAGE = 0;

  // status fields
  localparam int BIT_ST_SHORT_HPL = 0;
  localparam int BIT_ST_SHORT_HPR = 1;
  localparam int BIT_ST_SHORT_LNL = 2;
  localparam int BIT_ST_SHORT_LNR = 3;
  localparam int BIT_ST_MONO = 4;
  localparam int BIT_ST_STEREO = 5;

  localparam int SAMPLE_W = 16;

  typedef enum logic [1:0] {
    DPC_EMPHASIS_UNDO_SELECT_OFF, DPC_EMPHASIS_UNDO_SELECT_32K, DPC_EMPHASIS_UNDO_SELECT_44K1, DPC_EMPHASIS_UNDO_SELECT_48K
  } dpc_emphasis_undo_select_t;

  typedef enum logic {DPC_WB_IDLE, DPC_WB_ACK} dpc_wb_state_t;

  typedef struct packed {
    logic valid;
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } dpc_pair_t;

  typedef struct packed {
    logic ampOn;
    logic inputStageOn;
    logic midStageOn;
    logic outputStageOn;
    logic groundShort;
  } dpc_path_t;

endpackage

// [src/dpc_mono_mix.sv]
// module: stereo or attenuated mono sample routing towards the two converters
`timescale 1ns/1ps
module dpc_mono_mix (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic monoSelect,
  input wire logic leftConverterOn,
  input wire logic rightConverterOn,
  // samples
  input wire dpc_pkg::dpc_pair_t pairIn,
  output dpc_pkg::dpc_pair_t pairOut
);

  logic signed [dpc_pkg::SAMPLE_W:0] sum;
  logic signed [dpc_pkg::SAMPLE_W-1:0] half;
  logic oneOn;
  dpc_pkg::dpc_pair_t pairReg;

  // halving the sum is exactly -6 dB and can never clip
  assign sum = {pairIn.left[dpc_pkg::SAMPLE_W-1], pairIn.left}
             + {pairIn.right[dpc_pkg::SAMPLE_W-1], pairIn.right};
  assign half = sum[dpc_pkg::SAMPLE_W:1];
  assign oneOn = leftConverterOn ^ rightConverterOn;

  // one register stage; a disabled converter always gets silence
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pairReg <= '0;
    end else begin
      pairReg.valid <= pairIn.valid;
      if (monoSelect && oneOn) begin
        // mix goes only to the converter that is on
        pairReg.left <= leftConverterOn ? half : 16'h0000;
        pairReg.right <= rightConverterOn ? half : 16'h0000;
      end else begin
        // both on means stereo even with mono selected
        pairReg.left <= leftConverterOn ? pairIn.left : 16'h0000;
        pairReg.right <= rightConverterOn ? pairIn.right : 16'h0000;
      end
    end
  end

  assign pairOut = pairReg;

  property p_mono_atten;
    @(posedge sys_clk) disable iff (reset)
    monoSelect && leftConverterOn && !rightConverterOn
      |=> pairOut.left == $past(half);
  endproperty
  a_mono_atten: assert property (p_mono_atten)
    else $error("mono mix is not the halved sum");

  property p_mono_silent;
    @(posedge sys_clk) disable iff (reset)
    monoSelect && rightConverterOn && !leftConverterOn
      |=> pairOut.left == 16'h0000 && pairOut.right == $past(half);
  endproperty
  a_mono_silent: assert property (p_mono_silent)
    else $error("mono mix reached the disabled converter");

  property p_stereo;
    @(posedge sys_clk) disable iff (reset)
    leftConverterOn && rightConverterOn
      |=> pairOut.left == $past(pairIn.left)
          && pairOut.right == $past(pairIn.right);
  endproperty
  a_stereo: assert property (p_stereo)
    else $error("both converters on but output is not stereo");

  property p_route;
    @(posedge sys_clk) disable iff (reset)
    !monoSelect && leftConverterOn && !rightConverterOn
      |=> pairOut.left == $past(pairIn.left) && pairOut.right == 16'h0000;
  endproperty
  a_route: assert property (p_route)
    else $error("left data did not follow the left channel");

endmodule // dpc_mono_mix

// [src/dpc_dac_path.sv]
// module: dac path configuration registers, output enables and mono routing
//
// Behaviour
// - mono mode sums channels, attenuates 6 dB
// - mono mix only on the enabled converter
// - both converters on means stereo operation
// - mono select is bit 12, index 21h
// - de-emphasis bits 2:1 select off/32k/44.1k/48k
// - bit 11 selects sloping stopband filter
// - bit 6 doubles the oversampling ratio
// - left outputs from left, right from right
// - amp enables in 0Eh and 0Fh bits 1:0
// - outputs shorted to ground until released
`timescale 1ns/1ps
module dpc_dac_path (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sample stream
  input wire dpc_pkg::dpc_pair_t dacIn,
  output dpc_pkg::dpc_pair_t dacOut,
  // converter controls
  output dpc_pkg::dpc_emphasis_undo_select_t emphasisUndoSelect,
  output logic stopbandSlopeSelect,
  output logic oversampleDoubleSelect,
  output logic leftConverterOn,
  output logic rightConverterOn,
  // output driver controls
  output dpc_pkg::dpc_path_t hpLeftPath,
  output dpc_pkg::dpc_path_t hpRightPath,
  output dpc_pkg::dpc_path_t lineLeftPath,
  output dpc_pkg::dpc_path_t lineRightPath
);

  dpc_pkg::dpc_wb_state_t wbState_reg;
  logic [15:0] rdData_reg;
  logic [15:0] hpEn_reg;
  logic [15:0] lineEn_reg;
  logic [15:0] convEn_reg;
  logic [15:0] dacCtl_reg;
  logic [15:0] hpStage_reg;
  logic [15:0] lineStage_reg;
  logic [15:0] status;
  logic [7:0] regIdx;
  logic request;
  logic commit;

  // word index; the two low address bits are ignored, wb_sel_i picks the byte lanes
  assign regIdx = wb_adr_i[9:2];
  assign request = wb_cyc_i && wb_stb_i;
  // writes land on the edge where the master sees ack
  assign commit = request && wb_we_i && (wbState_reg == dpc_pkg::DPC_WB_ACK);

  // true for a committed write to the given index
  function automatic logic writeTo(input logic [7:0] idx);
    writeTo = commit && (regIdx == idx);
  endfunction

  // byte lane merge; only lanes 0 and 1 carry register bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] mask);
    logic [15:0] nv;
    nv = old;
    if (wb_sel_i[0]) begin
      nv[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      nv[15:8] = wb_dat_i[15:8];
    end
    merge = nv & mask;
  endfunction

  // implemented bits of each register; the rest read as zero
  localparam logic [15:0] MASK_PAIR = 16'h0003;
  localparam logic [15:0] MASK_CTL = 16'h1846;
  localparam logic [15:0] MASK_STAGE = 16'h00FF;

  // bus handshake: ack one cycle after the request, then drop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wbState_reg <= dpc_pkg::DPC_WB_IDLE;
    end else begin
      unique case (wbState_reg)
        dpc_pkg::DPC_WB_IDLE: begin
          if (request) begin
            wbState_reg <= dpc_pkg::DPC_WB_ACK;
          end
        end
        dpc_pkg::DPC_WB_ACK: begin
          wbState_reg <= dpc_pkg::DPC_WB_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o = (wbState_reg == dpc_pkg::DPC_WB_ACK) && request;

  // read data captured with the request; unmapped words read zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdData_reg <= 16'h0000;
    end else if (request && wbState_reg == dpc_pkg::DPC_WB_IDLE) begin
      unique case (regIdx)
        dpc_pkg::IDX_HP_EN: rdData_reg <= hpEn_reg;
        dpc_pkg::IDX_LINE_EN: rdData_reg <= lineEn_reg;
        dpc_pkg::IDX_CONV_EN: rdData_reg <= convEn_reg;
        dpc_pkg::IDX_DAC_CTL: rdData_reg <= dacCtl_reg;
        dpc_pkg::IDX_HP_STAGE: rdData_reg <= hpStage_reg;
        dpc_pkg::IDX_LINE_STAGE: rdData_reg <= lineStage_reg;
        dpc_pkg::IDX_STATUS: rdData_reg <= status;
        default: rdData_reg <= 16'h0000;
      endcase
    end
  end

  assign wb_dat_o = {16'h0000, rdData_reg};

  // headphone and line amp enables
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hpEn_reg <= dpc_pkg::RST_HP_EN;
      lineEn_reg <= dpc_pkg::RST_LINE_EN;
    end else begin
      if (writeTo(dpc_pkg::IDX_HP_EN)) begin
        hpEn_reg <= merge(hpEn_reg, MASK_PAIR);
      end
      if (writeTo(dpc_pkg::IDX_LINE_EN)) begin
        lineEn_reg <= merge(lineEn_reg, MASK_PAIR);
      end
    end
  end

  // converter channel enables
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      convEn_reg <= dpc_pkg::RST_CONV_EN;
    end else if (writeTo(dpc_pkg::IDX_CONV_EN)) begin
      convEn_reg <= merge(convEn_reg, MASK_PAIR);
    end
  end

  // dac digital control: mono, slope, oversampling, de-emphasis
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dacCtl_reg <= dpc_pkg::RST_DAC_CTL;
    end else if (writeTo(dpc_pkg::IDX_DAC_CTL)) begin
      dacCtl_reg <= merge(dacCtl_reg, MASK_CTL);
    end
  end

  // stage enables and short release; the order is software's job
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hpStage_reg <= dpc_pkg::RST_STAGE;
      lineStage_reg <= dpc_pkg::RST_STAGE;
    end else begin
      if (writeTo(dpc_pkg::IDX_HP_STAGE)) begin
        hpStage_reg <= merge(hpStage_reg, MASK_STAGE);
      end
      if (writeTo(dpc_pkg::IDX_LINE_STAGE)) begin
        lineStage_reg <= merge(lineStage_reg, MASK_STAGE);
      end
    end
  end

  // converter controls straight from the register bits
  assign emphasisUndoSelect = dpc_pkg::dpc_emphasis_undo_select_t'(
    dacCtl_reg[dpc_pkg::BIT_EMPHASIS_UNDO_SELECT_HI:dpc_pkg::BIT_EMPHASIS_UNDO_SELECT_LO]);
  assign stopbandSlopeSelect = dacCtl_reg[dpc_pkg::BIT_SLOPE];
  assign oversampleDoubleSelect = dacCtl_reg[dpc_pkg::BIT_OSR];
  assign leftConverterOn = convEn_reg[dpc_pkg::BIT_LEFT];
  assign rightConverterOn = convEn_reg[dpc_pkg::BIT_RIGHT];

  // driver paths; a cleared release bit keeps the pin on ground
  // no interlock against a bad order: the sequencer outside owns that
  assign hpLeftPath = '{
    ampOn: hpEn_reg[dpc_pkg::BIT_LEFT],
    inputStageOn: hpStage_reg[dpc_pkg::BIT_L_IN_STAGE],
    midStageOn: hpStage_reg[dpc_pkg::BIT_L_MID_STAGE],
    outputStageOn: hpStage_reg[dpc_pkg::BIT_L_OUT_STAGE],
    groundShort: !hpStage_reg[dpc_pkg::BIT_L_SHORT_REL]};
  assign hpRightPath = '{
    ampOn: hpEn_reg[dpc_pkg::BIT_RIGHT],
    inputStageOn: hpStage_reg[dpc_pkg::BIT_R_IN_STAGE],
    midStageOn: hpStage_reg[dpc_pkg::BIT_R_MID_STAGE],
    outputStageOn: hpStage_reg[dpc_pkg::BIT_R_OUT_STAGE],
    groundShort: !hpStage_reg[dpc_pkg::BIT_R_SHORT_REL]};
  assign lineLeftPath = '{
    ampOn: lineEn_reg[dpc_pkg::BIT_LEFT],
    inputStageOn: lineStage_reg[dpc_pkg::BIT_L_IN_STAGE],
    midStageOn: lineStage_reg[dpc_pkg::BIT_L_MID_STAGE],
    outputStageOn: lineStage_reg[dpc_pkg::BIT_L_OUT_STAGE],
    groundShort: !lineStage_reg[dpc_pkg::BIT_L_SHORT_REL]};
  assign lineRightPath = '{
    ampOn: lineEn_reg[dpc_pkg::BIT_RIGHT],
    inputStageOn: lineStage_reg[dpc_pkg::BIT_R_IN_STAGE],
    midStageOn: lineStage_reg[dpc_pkg::BIT_R_MID_STAGE],
    outputStageOn: lineStage_reg[dpc_pkg::BIT_R_OUT_STAGE],
    groundShort: !lineStage_reg[dpc_pkg::BIT_R_SHORT_REL]};

  // status word: shorts and the operating mode actually in force
  always_comb begin
    status = 16'h0000;
    status[dpc_pkg::BIT_ST_SHORT_HPL] = hpLeftPath.groundShort;
    status[dpc_pkg::BIT_ST_SHORT_HPR] = hpRightPath.groundShort;
    status[dpc_pkg::BIT_ST_SHORT_LNL] = lineLeftPath.groundShort;
    status[dpc_pkg::BIT_ST_SHORT_LNR] = lineRightPath.groundShort;
    status[dpc_pkg::BIT_ST_MONO] = dacCtl_reg[dpc_pkg::BIT_MONO]
      && (leftConverterOn ^ rightConverterOn);
    status[dpc_pkg::BIT_ST_STEREO] = leftConverterOn
      && rightConverterOn;
  end

  // sample routing, one cycle of latency
  dpc_mono_mix mixer (
    .sys_clk(sys_clk),
    .reset(reset),
    .monoSelect(dacCtl_reg[dpc_pkg::BIT_MONO]),
    .leftConverterOn(leftConverterOn),
    .rightConverterOn(rightConverterOn),
    .pairIn(dacIn),
    .pairOut(dacOut)
  );

  // a committed write on the bus to a given word
  sequence s_ctl_write;
    commit && regIdx == dpc_pkg::IDX_DAC_CTL && wb_sel_i[1];
  endsequence

  sequence s_ctl_low_write;
    commit && regIdx == dpc_pkg::IDX_DAC_CTL && wb_sel_i[0];
  endsequence

  sequence s_hp_write;
    commit && regIdx == dpc_pkg::IDX_HP_EN && wb_sel_i[0];
  endsequence

  sequence s_line_write;
    commit && regIdx == dpc_pkg::IDX_LINE_EN && wb_sel_i[0];
  endsequence

  property p_mono_field;
    @(posedge sys_clk) disable iff (reset)
    s_ctl_write |=> status[dpc_pkg::BIT_ST_MONO] ==
      ($past(wb_dat_i[dpc_pkg::BIT_MONO])
       && (leftConverterOn ^ rightConverterOn));
  endproperty
  a_mono_field: assert property (p_mono_field)
    else $error("mono select did not follow bit 12");

  property p_emphasis_undo_select_field;
    @(posedge sys_clk) disable iff (reset)
    s_ctl_low_write |=> emphasisUndoSelect ==
      $past(wb_dat_i[dpc_pkg::BIT_EMPHASIS_UNDO_SELECT_HI:dpc_pkg::BIT_EMPHASIS_UNDO_SELECT_LO]);
  endproperty
  a_emphasis_undo_select_field: assert property (p_emphasis_undo_select_field)
    else $error("de-emphasis select did not follow bits 2:1");

  property p_slope_field;
    @(posedge sys_clk) disable iff (reset)
    s_ctl_write |=> stopbandSlopeSelect ==
      $past(wb_dat_i[dpc_pkg::BIT_SLOPE]);
  endproperty
  a_slope_field: assert property (p_slope_field)
    else $error("filter type did not follow bit 11");

  property p_osr_field;
    @(posedge sys_clk) disable iff (reset)
    s_ctl_low_write |=> oversampleDoubleSelect ==
      $past(wb_dat_i[dpc_pkg::BIT_OSR]);
  endproperty
  a_osr_field: assert property (p_osr_field)
    else $error("oversampling select did not follow bit 6");

  property p_hp_amp;
    @(posedge sys_clk) disable iff (reset)
    s_hp_write |=> hpLeftPath.ampOn == $past(wb_dat_i[dpc_pkg::BIT_LEFT])
      && hpRightPath.ampOn == $past(wb_dat_i[dpc_pkg::BIT_RIGHT]);
  endproperty
  a_hp_amp: assert property (p_hp_amp)
    else $error("headphone amp enables did not follow bits 1:0");

  property p_short_holds;
    @(posedge sys_clk) disable iff (reset)
    hpLeftPath.groundShort && !writeTo(dpc_pkg::IDX_HP_STAGE)
      |=> hpLeftPath.groundShort;
  endproperty
  a_short_holds: assert property (p_short_holds)
    else $error("ground short released without a write");

  property p_ack_pulse;
    @(posedge sys_clk) disable iff (reset)
    request && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not given one cycle after request");

  property p_line_amp;
    @(posedge sys_clk) disable iff (reset)
    s_line_write |=>
      lineLeftPath.ampOn == $past(wb_dat_i[dpc_pkg::BIT_LEFT])
      && lineRightPath.ampOn == $past(wb_dat_i[dpc_pkg::BIT_RIGHT]);
  endproperty
  a_line_amp: assert property (p_line_amp)
    else $error("line amp enables did not follow bits 1:0");

  property p_line_short_holds;
    @(posedge sys_clk) disable iff (reset)
    lineRightPath.groundShort && !writeTo(dpc_pkg::IDX_LINE_STAGE)
      |=> lineRightPath.groundShort;
  endproperty
  a_line_short_holds: assert property (p_line_short_holds)
    else $error("line short released without a write");

  property p_ack_single;
    @(posedge sys_clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack held for more than one cycle");

  property p_ctl_holds;
    @(posedge sys_clk) disable iff (reset)
    !writeTo(dpc_pkg::IDX_DAC_CTL) |=> dacCtl_reg == $past(dacCtl_reg);
  endproperty
  a_ctl_holds: assert property (p_ctl_holds)
    else $error("dac control changed without a write");

  property p_hp_en_holds;
    @(posedge sys_clk) disable iff (reset)
    !writeTo(dpc_pkg::IDX_HP_EN) |=> hpEn_reg == $past(hpEn_reg);
  endproperty
  a_hp_en_holds: assert property (p_hp_en_holds)
    else $error("headphone amp enables changed without a write");

endmodule // dpc_dac_path

// [testbench/dpc_dac_path_tb.sv]
// testbench: register, output control and sample routing checks of dac path
`timescale 1ns/1ps
module dpc_dac_path_tb;
  logic sys_clk;
  logic reset;
  logic wbCyc, wbStb, wbWe, wbAck;
  logic [9:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO;
  dpc_pkg::dpc_pair_t dacIn, dacOut;
  dpc_pkg::dpc_emphasis_undo_select_t emphSel;
  logic slopeSel, osrSel, convL, convR;
  dpc_pkg::dpc_path_t hpL, hpR, lnL, lnR;
  int miscompares = 0;
  int totalChecks = 0;
  int cycleCount = 0;

  dpc_dac_path uut (
    .sys_clk(sys_clk), .reset(reset),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .dacIn(dacIn), .dacOut(dacOut),
    .emphasisUndoSelect(emphSel), .stopbandSlopeSelect(slopeSel),
    .oversampleDoubleSelect(osrSel), .leftConverterOn(convL),
    .rightConverterOn(convR), .hpLeftPath(hpL), .hpRightPath(hpR),
    .lineLeftPath(lnL), .lineRightPath(lnR)
  );

  // free running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard: the whole run needs a few thousand cycles at most
  always @(posedge sys_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      miscompares = miscompares + 1;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    totalChecks = totalChecks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  // one classic cycle; request held until the edge that samples ack high
  task automatic wb(input logic we, input logic [7:0] idx,
                    input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbSel <= 4'h3;
    wbDatI <= {16'h0000, d};
    // wait for the edge that samples ack high; only the hang guard ends it
    do begin
      @(posedge sys_clk);
    end while (wbAck !== 1'b1);
    q = wbDatO[15:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    // mid cycle, so callers see the register value the write left
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    wb(1'b0, idx, 16'h0000, q);
    chk({16'h0000, q}, {16'h0000, exp}, "register read");
  endtask

  // one sample in, result one edge later
  task automatic samp(input logic [15:0] l, input logic [15:0] r,
                      input logic [15:0] el, input logic [15:0] er);
    @(posedge sys_clk);
    dacIn <= {1'b1, l, r};
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({16'h0000, dacOut.left}, {16'h0000, el}, "left sample");
    chk({16'h0000, dacOut.right}, {16'h0000, er}, "right sample");
  endtask

  // reset state of registers and output controls
  task automatic t_reset_state();
    chk({12'h000, hpL, hpR, lnL, lnR} & 32'h0000_8421, 32'h0000_8421,
        "shorts at reset");
    rd(dpc_pkg::IDX_HP_EN, 16'h0000);
    rd(dpc_pkg::IDX_LINE_EN, 16'h0000);
    rd(dpc_pkg::IDX_DAC_CTL, 16'h0000);
    rd(dpc_pkg::IDX_STATUS, 16'h000F);
    wr(8'h33, 16'hFFFF);
    rd(8'h33, 16'h0000);
    wr(dpc_pkg::IDX_STATUS, 16'hFFFF);
    rd(dpc_pkg::IDX_STATUS, 16'h000F);
  endtask

  // every de-emphasis code with the filter and rate selects
  task automatic t_dac_ctl();
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 16'h0840 | (16'(i) << 1);
      wr(dpc_pkg::IDX_DAC_CTL, v);
      chk({30'h0, emphSel}, 32'(i), "de-emphasis select");
      chk({31'h0, slopeSel}, 32'h1, "stopband select");
      chk({31'h0, osrSel}, 32'h1, "oversample select");
      rd(dpc_pkg::IDX_DAC_CTL, v);
    end
    wr(dpc_pkg::IDX_DAC_CTL, 16'hFFFF);
    rd(dpc_pkg::IDX_DAC_CTL, 16'h1846);
    wr(dpc_pkg::IDX_DAC_CTL, 16'h0000);
    chk({28'h0, slopeSel, osrSel, emphSel}, 32'h0, "selects cleared");
  endtask

  // amp enables, then enable and disable stepping of the output stages
  task automatic t_paths();
    // reference and bias sit outside this block, taken as on here
    wr(dpc_pkg::IDX_HP_EN, 16'hFFFE);
    rd(dpc_pkg::IDX_HP_EN, 16'h0002);
    wr(dpc_pkg::IDX_LINE_EN, 16'h0001);
    chk({27'h0, hpL}, 32'h11, "hp left amp on");
    chk({27'h0, hpR}, 32'h01, "hp right amp off");
    chk({27'h0, lnL}, 32'h01, "line left amp off");
    wr(dpc_pkg::IDX_HP_STAGE, 16'h0010);
    chk({27'h0, hpL}, 32'h19, "hp left input stage");
    // at least 20 us between input and mid stage: 2000 cycles of 10 ns
    repeat (2000) @(posedge sys_clk);
    wr(dpc_pkg::IDX_HP_STAGE, 16'h0030);
    chk({27'h0, hpL}, 32'h1D, "hp left mid stage");
    // the offset correction step runs outside this block
    wr(dpc_pkg::IDX_HP_STAGE, 16'h0070);
    chk({27'h0, hpL}, 32'h1F, "hp left stages, short held");
    wr(dpc_pkg::IDX_HP_STAGE, 16'h00F0);
    chk({27'h0, hpL}, 32'h1E, "hp left short released");
    chk({27'h0, hpR}, 32'h01, "hp right still shorted");
    rd(dpc_pkg::IDX_STATUS, 16'h000E);
    wr(dpc_pkg::IDX_HP_STAGE, 16'h0070);
    chk({27'h0, hpL}, 32'h1F, "short reapplied first");
    wr(dpc_pkg::IDX_HP_STAGE, 16'h0000);
    chk({27'h0, hpL}, 32'h11, "stages cleared");
    wr(dpc_pkg::IDX_LINE_STAGE, 16'h0008);
    chk({27'h0, lnR}, 32'h10, "line right released");
    chk({27'h0, lnL}, 32'h01, "line left shorted");
    wr(dpc_pkg::IDX_LINE_STAGE, 16'h0000);
  endtask

  // stereo, mono on one converter, both on and both off
  task automatic t_routing();
    wr(dpc_pkg::IDX_CONV_EN, 16'h0003);
    samp(16'h1234, 16'h5678, 16'h1234, 16'h5678);
    wr(dpc_pkg::IDX_CONV_EN, 16'h0002);
    samp(16'h1234, 16'h5678, 16'h1234, 16'h0000);
    wr(dpc_pkg::IDX_DAC_CTL, 16'h1000);
    wr(dpc_pkg::IDX_CONV_EN, 16'h0003);
    chk({30'h0, convL, convR}, 32'h3, "both converters on");
    samp(16'h1000, 16'h3000, 16'h1000, 16'h3000);
    wr(dpc_pkg::IDX_CONV_EN, 16'h0002);
    samp(16'h1000, 16'h3000, 16'h2000, 16'h0000);
    samp(16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h0000);
    rd(dpc_pkg::IDX_STATUS, 16'h001F);
    wr(dpc_pkg::IDX_CONV_EN, 16'h0001);
    chk({30'h0, convL, convR}, 32'h1, "right converter only");
    samp(16'hFFFD, 16'hFFFE, 16'h0000, 16'hFFFD);
    samp(16'h8000, 16'h8000, 16'h0000, 16'h8000);
    wr(dpc_pkg::IDX_CONV_EN, 16'h0000);
    samp(16'h1000, 16'h3000, 16'h0000, 16'h0000);
  endtask

  // main sequence
  initial begin
    reset = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 10'h000;
    wbSel = 4'h0;
    wbDatI = 32'h0000_0000;
    dacIn = '0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    t_reset_state();
    t_dac_ctl();
    t_paths();
    t_routing();
    end_of_test();
  end
endmodule // dpc_dac_path_tb
